/* File: logic/cltp_pkg.sv */
// Constants, register map and state types for the calibration trigger
// and low-power calibration controller.
// Assumes an APB master with 32-bit data and a 12-bit byte address.
//
// Summary of operation
// [R1] Status-select picks pin source or forces low
// [R2] Source bit 0: software trigger bit used
// [R3] Source bit 1: synchronised trigger pin used
// [R4] Software trigger resets high; keep idle high
// [R5] Sleep code, reset 4, for autonomous sleep
// [R6] Sleep time (2^k+1)*256 clocks per code
// [R7] Sleep codes below 4 save little power
// [R8] Wake code, reset 1, settling after wake
// [R9] Wake time (2^k+1)*256 clocks per code
// [R10] Wake code 0 gives the longest settling
// [R11] Trigger-sleep 0: sleep timed by counter
// [R12] Trigger-sleep 1: wake while trigger low
// [R13] Low-power only with background calibration enabled
// [R14] Background enable bit drives engine enable
// [R15] Foreground-done flag mirrored when selected
// [R16] Calibration-stopped flag mirrored when selected
// [R17] Trigger synchronised; delay codes apply next interval
`default_nettype none

package cltp_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] PIN_CFG_IDX   = 10'h06B;
  localparam logic [9:0] SOFT_TRIG_IDX = 10'h06C;
  localparam logic [9:0] LP_CFG_IDX    = 10'h06E;
  localparam logic [9:0] CTRL_IDX      = 10'h040;
  localparam logic [9:0] STATE_IDX     = 10'h041;
  localparam logic [9:0] IRQ_ST_IDX    = 10'h042;
  localparam logic [9:0] IRQ_MASK_IDX  = 10'h043;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] PIN_CFG_RST   = 8'h00;
  localparam logic [7:0] SOFT_TRIG_RST = 8'h01;
  localparam logic [7:0] LP_CFG_RST    = 8'h88;
  localparam int TRIG_SRC_BIT = 0;
  localparam int STAT_SEL_LO  = 1;
  localparam int SOFT_BIT     = 0;
  localparam int LOW_POWER_ENABLE_BIT = 0;
  localparam int TRIG_SLEEP_BIT       = 1;
  localparam int WAKE_LO      = 3;
  localparam int SLEEP_LO     = 5;
  localparam int BG_EN_BIT    = 0;

  localparam logic [1:0] SEL_DONE_FLAG = 2'h0;
  localparam logic [1:0] SEL_STOPPED = 2'h1;
  localparam logic [1:0] SEL_ALARM   = 2'h2;

  // ----------------------------------------------------------------
  // Interrupt events and timing
  // ----------------------------------------------------------------
  localparam int IRQ_W   = 3;
  localparam int EV_WAKE = 0;
  localparam int EV_CAL  = 1;
  localparam int EV_TFALL = 2;
  localparam int LP_TICK_CYCLES = 256;
  localparam logic [7:0] TICK_LAST = 8'(LP_TICK_CYCLES - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_SLEEP, ST_WAKE, ST_CAL} cltp_lp_state_t;

  typedef struct packed {
    logic [7:0]      pin_cfg;
    logic [7:0]      soft_trig;
    logic [7:0]      lp_cfg;
    logic            bg_en;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic            trig_s1;
    logic            trig_s2;
    logic            trig_sel;
    logic            status_pin;
    cltp_lp_state_t  st;
    logic [7:0]      pre;
    logic [33:0]     ticks;
    logic            adc_sleep;
    logic            cal_req;
    logic            irq;
    logic            pready;
    logic [31:0]     prdata;
    logic            pslverr;
  } cltp_regs_t;

endpackage

`default_nettype wire

/* File: logic/cltp_ctrl.sv */
// Calibration trigger select, status pin mux and low-power sleep/wake
// scheduler with an APB register slave.
// Assumes a single clock pclk; trigger pin treated as asynchronous level.
`default_nettype none

module cltp_ctrl
  import cltp_pkg::*;
#(
  parameter int unsigned EXP_REDUCE = 0    // Lowers every delay exponent
)
(
  input  wire logic        pclk,                 // 20 MHz clock
  input  wire logic        presetn,              // Async reset, low
  input  wire logic        psel,                 // APB select
  input  wire logic        penable,              // APB enable
  input  wire logic        pwrite,               // APB write
  input  wire logic [11:0] paddr,                // APB byte address
  input  wire logic [31:0] pwdata,               // APB write data
  output logic             pready,               // APB ready
  output logic      [31:0] prdata,               // APB read data
  output logic             pslverr,              // APB error
  input  wire logic        cal_trigger_pin,      // Hardware trigger
  input  wire logic        foreground_done_flag, // Engine flag
  input  wire logic        cal_stopped_flag,     // Engine flag
  input  wire logic        alarm_flag,           // Alarm flag
  input  wire logic        lp_cal_done,          // Woken ADC calibrated
  output logic             cal_status_pin,       // Status pin
  output logic             cal_trigger,          // Selected trigger
  output logic             background_cal_enable,// Engine enable
  output logic             adc_sleep,            // ADC held asleep
  output logic             adc_cal_request,      // Calibrate woken ADC
  output logic             irq                   // Interrupt level
);

  cltp_regs_t r;
  cltp_regs_t next_r;

  // ----------------------------------------------------------------
  // Delay lookups
  // ----------------------------------------------------------------
  function automatic logic [33:0] ticks_of(input logic [5:0] k);
    logic [5:0] kk;
    kk = (32'(k) > EXP_REDUCE) ? 6'(32'(k) - EXP_REDUCE) : 6'h00;
    return (34'h000000001 << kk) + 34'h000000001;
  endfunction

  function automatic logic [33:0] sleep_ticks(input logic [2:0] code);
    logic [5:0] k;
    unique case (code)
      3'h0: k = 6'd3;
      3'h1: k = 6'd15;
      3'h2: k = 6'd18;
      3'h3: k = 6'd21;
      3'h4: k = 6'd24;
      3'h5: k = 6'd27;
      3'h6: k = 6'd30;
      3'h7: k = 6'd33;
    endcase
    return ticks_of(k);
  endfunction

  function automatic logic [33:0] wake_ticks(input logic [1:0] code);
    logic [5:0] k;
    unique case (code)
      2'h0: k = 6'd33;
      2'h1: k = 6'd18;
      2'h2: k = 6'd21;
      2'h3: k = 6'd24;
    endcase
    return ticks_of(k);
  endfunction

  // ----------------------------------------------------------------
  // Decoded fields
  // ----------------------------------------------------------------
  logic       lp_active;
  logic       trig_sleep;
  logic [1:0] stat_sel;
  logic       interval_end;
  logic       acc;
  logic       wr_now;
  logic [9:0] idx;
  logic [IRQ_W-1:0] ev;

  assign lp_active  = r.lp_cfg[LOW_POWER_ENABLE_BIT] && r.bg_en;    // see [R13]
  assign trig_sleep = r.lp_cfg[TRIG_SLEEP_BIT];
  assign stat_sel  = r.pin_cfg[STAT_SEL_LO +: 2];
  assign interval_end = (r.pre == TICK_LAST) && (r.ticks == 34'h000000001);
  assign acc    = psel && penable;
  assign wr_now = acc && pwrite && r.pready;
  assign idx    = paddr[11:2];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    ev     = '0;

    next_r.trig_s1 = cal_trigger_pin;                   // see [R17]
    next_r.trig_s2 = r.trig_s1;
    next_r.trig_sel = r.pin_cfg[TRIG_SRC_BIT] ? r.trig_s2    // see [R3]
                                              : r.soft_trig[SOFT_BIT]; // see [R2]
    if (r.trig_sel && !next_r.trig_sel)
      ev[EV_TFALL] = 1'b1;

    unique case (stat_sel)                              // see [R1]
      SEL_DONE_FLAG: next_r.status_pin = foreground_done_flag;  // see [R15]
      SEL_STOPPED: next_r.status_pin = cal_stopped_flag;      // see [R16]
      SEL_ALARM:   next_r.status_pin = alarm_flag;
      default:     next_r.status_pin = 1'b0;
    endcase

    if (r.pre == TICK_LAST)
    begin
      next_r.pre   = 8'h00;
      next_r.ticks = r.ticks - 34'h000000001;
    end
    else
      next_r.pre = r.pre + 8'h01;

    if (!lp_active)
      next_r.st = ST_IDLE;                              // see [R13]
    else
      unique case (r.st)
        ST_IDLE:
        begin
          next_r.st    = ST_SLEEP;
          next_r.pre   = 8'h00;
          next_r.ticks = sleep_ticks(r.lp_cfg[SLEEP_LO +: 3]);  // see [R5]
        end
        ST_SLEEP:
          if (trig_sleep ? !r.trig_sel : interval_end)  // see [R11] see [R12]
          begin
            next_r.st    = ST_WAKE;
            next_r.pre   = 8'h00;
            next_r.ticks = wake_ticks(r.lp_cfg[WAKE_LO +: 2]);  // see [R8] see [R9]
            ev[EV_WAKE]  = 1'b1;
          end
        ST_WAKE:
          if (interval_end)
          begin
            next_r.st   = ST_CAL;
            ev[EV_CAL]  = 1'b1;
          end
        ST_CAL:
          if (lp_cal_done)
          begin
            next_r.st    = ST_SLEEP;
            next_r.pre   = 8'h00;
            next_r.ticks = sleep_ticks(r.lp_cfg[SLEEP_LO +: 3]);  // see [R6] see [R17]
          end
      endcase
    next_r.adc_sleep = (next_r.st == ST_SLEEP);
    next_r.cal_req   = (next_r.st == ST_CAL);

    // APB: one wait state, answer latched on the same edge that raises pready
    next_r.pready = 1'b0;
    if (acc && !r.pready)
    begin
      next_r.pready  = 1'b1;
      next_r.pslverr = 1'b0;
      next_r.prdata  = 32'h00000000;
      if (paddr[1:0] != 2'h0)
        next_r.pslverr = 1'b1;
      else
        unique case (idx)
          PIN_CFG_IDX:   next_r.prdata[7:0] = r.pin_cfg;
          SOFT_TRIG_IDX: next_r.prdata[7:0] = r.soft_trig;
          LP_CFG_IDX:    next_r.prdata[7:0] = r.lp_cfg;
          CTRL_IDX:      next_r.prdata[BG_EN_BIT] = r.bg_en;
          STATE_IDX:     next_r.prdata[7:0] = {r.cal_req, r.adc_sleep, r.st, r.trig_sel,
                                               alarm_flag, cal_stopped_flag, foreground_done_flag};
          IRQ_ST_IDX:    next_r.prdata[IRQ_W-1:0] = r.irq_st;
          IRQ_MASK_IDX:  next_r.prdata[IRQ_W-1:0] = r.irq_mask;
          default:       next_r.pslverr = 1'b1;
        endcase
    end

    if (wr_now && paddr[1:0] == 2'h0)
      unique case (idx)
        PIN_CFG_IDX:   next_r.pin_cfg   = pwdata[7:0];
        SOFT_TRIG_IDX: next_r.soft_trig = pwdata[7:0];
        LP_CFG_IDX:    next_r.lp_cfg    = pwdata[7:0];
        CTRL_IDX:      next_r.bg_en     = pwdata[BG_EN_BIT];    // see [R14]
        IRQ_ST_IDX:    next_r.irq_st    = r.irq_st & ~pwdata[IRQ_W-1:0];
        IRQ_MASK_IDX:  next_r.irq_mask  = pwdata[IRQ_W-1:0];
        default:       next_r.irq_st    = r.irq_st;
      endcase
    // Events win over a same-cycle clear
    next_r.irq_st = next_r.irq_st | ev;
    next_r.irq    = |(next_r.irq_st & next_r.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r           <= '0;
      r.pin_cfg   <= PIN_CFG_RST;
      r.soft_trig <= SOFT_TRIG_RST;                     // see [R4]
      r.lp_cfg    <= LP_CFG_RST;
      r.trig_sel  <= 1'b1;
      // Synchroniser starts at the pin's idle level, no false fall
      r.trig_s1   <= 1'b1;
      r.trig_s2   <= 1'b1;
      r.st        <= ST_IDLE;
    end
    else
      r <= next_r;
  end

  assign pready                = r.pready;
  assign prdata                = r.prdata;
  assign pslverr               = r.pslverr;
  assign cal_status_pin        = r.status_pin;
  assign cal_trigger           = r.trig_sel;
  assign background_cal_enable = r.bg_en;
  assign adc_sleep             = r.adc_sleep;
  assign adc_cal_request       = r.cal_req;
  assign irq                   = r.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [47:0] h_cnt;
  logic [33:0] h_len;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      h_cnt <= '0;
      h_len <= '0;
    end
    else if (r.st != next_r.st)
    begin
      h_cnt <= '0;
      h_len <= next_r.ticks;
    end
    else
      h_cnt <= h_cnt + 48'h1;
  end

  sequence s_timed_sleep_exit;
    r.st == ST_SLEEP && next_r.st == ST_WAKE && !trig_sleep;
  endsequence

  sequence s_wake_exit;
    r.st == ST_WAKE && next_r.st == ST_CAL;
  endsequence

  property p_force_low;
    @(posedge pclk) disable iff (!presetn)
    stat_sel == 2'h3 |=> !cal_status_pin;
  endproperty
  a_force_low: assert property (p_force_low) else $error("status pin not low"); // see [R1]

  property p_soft_src;
    @(posedge pclk) disable iff (!presetn)
    !r.pin_cfg[TRIG_SRC_BIT] |=> cal_trigger == $past(r.soft_trig[SOFT_BIT]);
  endproperty
  a_soft_src: assert property (p_soft_src) else $error("soft trigger not used"); // see [R2]

  property p_pin_src;
    @(posedge pclk) disable iff (!presetn)
    r.pin_cfg[TRIG_SRC_BIT] |=> cal_trigger == $past(cal_trigger_pin, 3);
  endproperty
  a_pin_src: assert property (p_pin_src) else $error("pin trigger not used"); // see [R3]

  property p_sleep_len;
    @(posedge pclk) disable iff (!presetn)
    s_timed_sleep_exit |-> h_cnt + 48'h1 == 48'(h_len) * 48'(LP_TICK_CYCLES);
  endproperty
  a_sleep_len: assert property (p_sleep_len) else $error("sleep length wrong"); // see [R6]

  property p_wake_len;
    @(posedge pclk) disable iff (!presetn)
    s_wake_exit |-> h_cnt + 48'h1 == 48'(h_len) * 48'(LP_TICK_CYCLES);
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake length wrong"); // see [R9]

  property p_trig_wake;
    @(posedge pclk) disable iff (!presetn)
    lp_active && trig_sleep && r.st == ST_SLEEP && !cal_trigger ##1 lp_active
      |-> r.st == ST_WAKE && !adc_sleep;
  endproperty
  a_trig_wake: assert property (p_trig_wake) else $error("no wake on low trigger"); // see [R12]

  property p_trig_hold;
    @(posedge pclk) disable iff (!presetn)
    lp_active && trig_sleep && r.st == ST_SLEEP && cal_trigger |=> adc_sleep;
  endproperty
  a_trig_hold: assert property (p_trig_hold) else $error("woke with trigger high"); // see [R12]

  property p_lp_off;
    @(posedge pclk) disable iff (!presetn)
    !lp_active |=> !adc_sleep && !adc_cal_request;
  endproperty
  a_lp_off: assert property (p_lp_off) else $error("low power ran while off"); // see [R13]

  property p_bg_write;
    @(posedge pclk) disable iff (!presetn)
    wr_now && paddr == {CTRL_IDX, 2'h0} |=> background_cal_enable == $past(pwdata[BG_EN_BIT]);
  endproperty
  a_bg_write: assert property (p_bg_write) else $error("background enable not written"); // see [R14]

  property p_fg_mirror;
    @(posedge pclk) disable iff (!presetn)
    stat_sel == SEL_DONE_FLAG |=> cal_status_pin == $past(foreground_done_flag);
  endproperty
  a_fg_mirror: assert property (p_fg_mirror) else $error("done flag not mirrored"); // see [R15]

  property p_stop_mirror;
    @(posedge pclk) disable iff (!presetn)
    stat_sel == SEL_STOPPED |=> cal_status_pin == $past(cal_stopped_flag);
  endproperty
  a_stop_mirror: assert property (p_stop_mirror) else $error("stopped flag not mirrored"); // see [R16]

  property p_alarm_mirror;
    @(posedge pclk) disable iff (!presetn)
    stat_sel == SEL_ALARM |=> cal_status_pin == $past(alarm_flag);
  endproperty
  a_alarm_mirror: assert property (p_alarm_mirror) else $error("alarm flag not mirrored"); // see [R1]

  property p_settle_first;
    @(posedge pclk) disable iff (!presetn)
    r.st == ST_WAKE && !interval_end |=> !adc_cal_request;
  endproperty
  a_settle_first: assert property (p_settle_first) else $error("calibrated before settling"); // see [R8]

  sequence s_wake_entry;
    r.st == ST_SLEEP && next_r.st == ST_WAKE;
  endsequence

  property p_wake_event;
    @(posedge pclk) disable iff (!presetn)
    s_wake_entry |=> r.irq_st[EV_WAKE];
  endproperty
  a_wake_event: assert property (p_wake_event) else $error("wake event not flagged");

  property p_apb_wait;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("no answer after one wait state");

  property p_apb_pulse;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_apb_pulse: assert property (p_apb_pulse) else $error("ready held too long");

endmodule

`default_nettype wire

/* File: testbench/cltp_host.sv */
// Host-side model: drives the trigger pin and samples the status pin.
// Assumes the bench asks for the trigger level; the pin moves after a rising edge.
`default_nettype none

module cltp_host
(
  input  wire logic pclk,     // Device clock
  input  wire logic want_low, // Bench asks trigger low
  input  wire logic stat_pin, // Status pin from device
  output var  logic trig_pin, // Trigger pin to device
  output var  logic stat_seen // Last sampled status
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle high when no trigger is wanted
  initial trig_pin = 1'b1;

  always @(posedge pclk)
  begin
    trig_pin  <= ~want_low;
    stat_seen <= stat_pin;
  end
endmodule

`default_nettype wire

/* File: testbench/cltp_ctrl_bench.sv */
// Self-checking bench for the calibration trigger and low-power controller.
// Assumes EXP_REDUCE of 21, so long sleep and wake counts stay short.
`default_nettype none

module cltp_ctrl_bench
  import cltp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk, presetn, psel, penable, pwrite, want_low;
  logic        fg, stp, alm, lpd, pready, pslverr, pin, stat, seen;
  logic        ctrig, bgen, slp, creq, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_errors, n_checks;

  always #25 pclk = ~pclk;

  cltp_ctrl #(.EXP_REDUCE(21)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cal_trigger_pin(pin), .foreground_done_flag(fg),
    .cal_stopped_flag(stp), .alarm_flag(alm), .lp_cal_done(lpd), .cal_status_pin(stat),
    .cal_trigger(ctrig), .background_cal_enable(bgen), .adc_sleep(slp),
    .adc_cal_request(creq), .irq(irq));

  cltp_host HOST (.pclk(pclk), .want_low(want_low), .stat_pin(stat), .trig_pin(pin),
    .stat_seen(seen));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s exp %0h got %0h", n, e, g);
      n_errors++;
    end
  endtask

  task automatic limit(input int i, input int lim);
    if (i >= lim)
    begin
      $display("[FAIL] wait exp below %0d got %0d", lim, i);
      n_errors++;
      give_verdict;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    int i;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    limit((pready === 1'b1) ? 0 : 20, 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    chk("trig rst", 32'h1, 32'(ctrig));
    apb(1'b0, PIN_CFG_IDX, 32'h0);
    chk("pin_cfg rst", 32'h0, rd);
    apb(1'b0, SOFT_TRIG_IDX, 32'h0);
    chk("soft rst", 32'h1, rd);
    apb(1'b0, LP_CFG_IDX, 32'h0);
    chk("lp rst", 32'h88, rd);
    apb(1'b1, PIN_CFG_IDX, 32'hA5);
    apb(1'b0, PIN_CFG_IDX, 32'h0);
    chk("pin_cfg rw", 32'hA5, rd);
    apb(1'b0, 10'h3FF, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    $display("t_regs done");
  endtask

  task automatic t_status;
    logic [2:0] p;
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, PIN_CFG_IDX, 32'(s << 1));
      for (int j = 0; j < 6; j++)
      begin
        p = (j > 2) ? ~(3'h1 << (j - 3)) : (3'h1 << j);
        {alm, stp, fg} <= p;
        cyc(4);
        chk("status pin", (s == 3) ? 32'h0 : 32'(p[s]), 32'(seen));
      end
    end
    $display("t_status done");
  endtask

  task automatic t_trig;
    apb(1'b1, PIN_CFG_IDX, 32'h0);
    want_low <= 1'b1;
    apb(1'b1, SOFT_TRIG_IDX, 32'h1);
    cyc(5);
    chk("soft high", 32'h1, 32'(ctrig));
    apb(1'b1, SOFT_TRIG_IDX, 32'h0);
    cyc(2);
    chk("soft low", 32'h0, 32'(ctrig));
    want_low <= 1'b0;
    cyc(5);
    chk("pin ignored", 32'h0, 32'(ctrig));
    apb(1'b1, PIN_CFG_IDX, 32'h1);
    cyc(2);
    chk("pin high", 32'h1, 32'(ctrig));
    apb(1'b1, IRQ_ST_IDX, 32'h7);
    want_low <= 1'b1;
    cyc(5);
    chk("pin low", 32'h0, 32'(ctrig));
    apb(1'b1, SOFT_TRIG_IDX, 32'h1);
    cyc(2);
    chk("soft ignored", 32'h0, 32'(ctrig));
    apb(1'b0, IRQ_ST_IDX, 32'h0);
    chk("fall event", 32'h4, rd & 32'h4);
    want_low <= 1'b0;
    $display("t_trig done");
  endtask

  task automatic t_lp;
    int n;
    apb(1'b1, IRQ_ST_IDX, 32'h7);
    apb(1'b1, CTRL_IDX, 32'h1);
    chk("bg enable", 32'h1, 32'(bgen));
    apb(1'b1, LP_CFG_IDX, 32'h89);
    n = 0;
    while (slp !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    limit(n, 20);
    n = 0;
    while (slp === 1'b1 && n < 9000)
    begin
      @(posedge pclk);
      n++;
    end
    chk("sleep cycles", 32'd2304, 32'(n));
    limit(n, 9000);
    n = 0;
    while (slp !== 1'b1 && creq !== 1'b1 && n < 9000)
    begin
      @(posedge pclk);
      n++;
    end
    chk("wake cycles", 32'd512, 32'(n));
    limit(n, 9000);
    chk("cal request", 32'h1, 32'(creq));
    apb(1'b0, STATE_IDX, 32'h0);
    chk("state word", 32'hBB, rd);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, IRQ_MASK_IDX, 32'h1);
    chk("irq wake", 32'h1, 32'(irq));
    apb(1'b1, IRQ_ST_IDX, 32'h1);
    chk("irq clear", 32'h0, 32'(irq));
    lpd <= 1'b1;
    @(posedge pclk);
    lpd <= 1'b0;
    cyc(3);
    chk("asleep again", 32'h1, 32'(slp));
    chk("request off", 32'h0, 32'(creq));
    apb(1'b1, CTRL_IDX, 32'h0);
    cyc(2);
    chk("lp needs bg", 32'h0, 32'(slp));
    chk("bg disable", 32'h0, 32'(bgen));
    $display("t_lp done");
  endtask

  task automatic t_trigsleep;
    apb(1'b1, PIN_CFG_IDX, 32'h1);
    apb(1'b1, LP_CFG_IDX, 32'h8B);
    apb(1'b1, CTRL_IDX, 32'h1);
    cyc(3000);
    chk("held asleep", 32'h1, 32'(slp));
    want_low <= 1'b1;
    cyc(8);
    chk("woken by trig", 32'h0, 32'(slp));
    want_low <= 1'b0;
    $display("t_trigsleep done");
  endtask

  task automatic t_reset;
    presetn <= 1'b0;
    cyc(2);
    chk("bg after reset", 32'h0, 32'(bgen));
    chk("trig after reset", 32'h1, 32'(ctrig));
    chk("irq after reset", 32'h0, 32'(irq));
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, LP_CFG_IDX, 32'h0);
    chk("lp after reset", 32'h88, rd);
    $display("t_reset done");
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    want_low = 1'b0;
    {alm, stp, fg} = 3'h0;
    lpd = 1'b0;
    n_errors = 0;
    n_checks = 0;
    cyc(10);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_status;
    t_trig;
    t_lp;
    t_trigsleep;
    t_reset;
    give_verdict;
  end
endmodule

`default_nettype wire
